/* rtl/eis_pkg.sv */
// Constants, field layout and state codes for the event entry sequencer
package eis_pkg;
   localparam int          CC_LSB    = 0;
   localparam int          CC_W      = 4;
   localparam int          IPL_LSB   = 16;
   localparam int          IPL_W     = 5;
   localparam int          PREV_LSB  = 22;
   localparam int          CUR_LSB   = 24;
   localparam int          MODE_W    = 2;
   localparam int          IS_BIT    = 26;
   localparam int          TP_BIT    = 30;
   localparam logic [4:0]  IPL_KSNV  = 5'h1f;
   localparam logic [1:0]  VEC_KSTK  = 2'h0;
   localparam logic [1:0]  VEC_ISTK  = 2'h1;
   localparam logic [1:0]  MODE_KERN = 2'h0;
   localparam logic [31:0] LW_BYTES  = 32'h4;
   localparam logic [31:0] PSL_RST   = 32'h0;
   localparam int          PAR_W     = 3;
   // Stack pointer index equals PROCESSOR_STATUS_LONGWORD bits 26:24 (IS, current mode)
   localparam logic [2:0]  SPX_KERN  = 3'h0;
   localparam logic [2:0]  SPX_INT   = 3'h4;
   localparam int          SP_NUM    = 5;

   typedef enum logic [3:0] {
      EV_ABORT = 4'h0,
      EV_BPT   = 4'h1,
      EV_CHM   = 4'h2,
      EV_FAULT = 4'h3,
      EV_INTR  = 4'h4,
      EV_TRACE = 4'h5,
      EV_TRAP  = 4'h6,
      EV_RESV  = 4'h7,
      EV_XFC   = 4'h8
   } eis_cause_t;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_SWITCH   = 3'h1,
      ST_PUSH_PSL = 3'h2,
      ST_PUSH_PC  = 3'h3,
      ST_INIT_PSL = 3'h4,
      ST_PUSH_PAR = 3'h5,
      ST_JUMP     = 3'h6,
      ST_HALT     = 3'h7
   } eis_state_t;
endpackage

/* rtl/eis_sp_bank.sv */
// Five stack pointers with a sequencer port and a privileged register port
`timescale 1ns/1ps
`default_nettype none
module eis_sp_bank (
   input  wire logic        mclk,      // Clock
   input  wire logic        rst,       // Sync reset
   input  wire logic        seq_we,    // Sequencer write
   input  wire logic [2:0]  seq_idx,   // Sequencer write index
   input  wire logic [31:0] seq_wdata, // Sequencer write data
   input  wire logic [2:0]  seq_ridx,  // Sequencer read index
   output logic      [31:0] seq_rdata, // Sequencer read data
   input  wire logic        prv_we,    // Privileged register write
   input  wire logic [2:0]  prv_idx,   // Privileged register index
   input  wire logic [31:0] prv_wdata, // Privileged write data
   output logic      [31:0] prv_rdata  // Privileged read data
);
   logic [31:0] sp_q [eis_pkg::SP_NUM];

   // Sequencer wins a same-cycle clash so a stack switch is never lost
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < eis_pkg::SP_NUM; i++) begin
            sp_q[i] <= 32'h0;
         end
      end else if (seq_we) begin
         sp_q[seq_idx] <= seq_wdata;
      end else if (prv_we && (prv_idx <= eis_pkg::SPX_INT)) begin
         sp_q[prv_idx] <= prv_wdata;
      end
   end

   assign seq_rdata = (seq_ridx <= eis_pkg::SPX_INT) ? sp_q[seq_ridx] : 32'h0;
   assign prv_rdata = (prv_idx <= eis_pkg::SPX_INT) ? sp_q[prv_idx] : 32'h0;
endmodule // eis_sp_bank
`default_nettype wire

/* rtl/eis_entry_seq.sv */
// Exception and interrupt entry sequencer: stack switch, pushes, new status, vector jump
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Vector low two bits choose event handling
// - Interrupts disabled throughout the entry sequence
// - Clear condition codes when code is 0/1
// - Off interrupt stack: save SP, load new
// - Push old status before program counter
// - Push PC except between-instruction interrupts, traps
// - Build new status after the saves
// - Change priority level only for interrupts
// - Then push every event parameter
// - Exceptions: previous mode takes old current mode
// - Finally jump to vector bits 31:2
// - Kernel stack write fault: abort, level 1F
// - Abort discards original event parameters
// - Abort pushes same status, PC on interrupt stack
// - Interrupt stack write fault halts, values kept
// - Saved trace pending per event cause
// - Interrupts: trace clear flag clears trace pending
// - Abort PC addresses aborting instruction
// - Interrupt PC: interrupted or next instruction; code always saves cur_pc
// - Stack pointers held in privileged registers
// - Privileged moves reach all stack pointers
// - Stack select from interrupt flag and mode
// - Entry clears current mode bits
module eis_entry_seq (
   input  wire logic        mclk,           // Clock, 50 MHz
   input  wire logic        rst,            // Sync reset, active high
   input  wire logic        ev_start,       // Start entry, one-cycle pulse
   input  wire logic [3:0]  ev_cause,       // Event cause code
   input  wire logic        ev_between,     // Interrupt taken between instructions
   input  wire logic        itc_flag,       // Interrupt trace clear flag
   input  wire logic [4:0]  ev_ipl,         // Priority level of an interrupt
   input  wire logic [31:0] ev_vector,      // Fetched vector longword
   input  wire logic [31:0] ksnv_vector,    // Vector used for kernel stack abort
   input  wire logic [31:0] cur_psl,        // Current status longword
   input  wire logic [31:0] cur_pc,         // PC of the current instruction
   input  wire logic [31:0] next_pc,        // PC of the next instruction
   input  wire logic [31:0] cur_sp,         // Live stack pointer from the core
   input  wire logic [2:0]  par_cnt,        // Number of event parameters
   input  wire logic [31:0] par_data,       // Parameter selected by par_idx
   output logic      [2:0]  par_idx,        // Parameter being pushed
   output logic             mem_wr_req,     // Stack write request
   output logic      [31:0] mem_wr_addr,    // Stack write address
   output logic      [31:0] mem_wr_data,    // Stack write data
   input  wire logic        mem_wr_ack,     // Write completed
   input  wire logic        mem_wr_acv,     // Access violation with ack
   input  wire logic        mem_wr_tnv,     // Translation not valid with ack
   input  wire logic        prv_we,         // Privileged stack pointer write
   input  wire logic [2:0]  prv_idx,        // Privileged register index
   input  wire logic [31:0] prv_wdata,      // Privileged write data
   output logic      [31:0] prv_rdata,      // Privileged read data
   output logic             int_disable,    // Interrupt recognition blocked
   output logic             busy,           // Sequence in progress
   output logic             done,           // Entry finished, one-cycle pulse
   output logic             ksnv_abort,     // Kernel stack abort began, pulse
   output logic             halted,         // Halted, level
   output logic      [31:0] new_psl,        // Handler status longword
   output logic      [31:0] new_pc,         // Handler PC
   output logic      [31:0] new_sp          // Handler stack pointer
);
   eis_pkg::eis_state_t state_q;
   eis_pkg::eis_cause_t cause_q;
   logic [31:0] vec_q, opsl_q, spsl_q, spc_q, sp_q, npsl_q, npc_q;
   logic [2:0]  stk_q, par_q, pcnt_q;
   logic        pushpc_q, ksnv_q, done_q, ksnv_p_q, halt_q;
   logic        intr, wr_fault, bank_we;
   logic [2:0]  bank_idx, bank_ridx, stk_new;
   logic [31:0] bank_wdata, bank_rdata, sp_dec;
   logic        tp_save;
   logic [31:0] pc_save;

   assign intr     = (cause_q == eis_pkg::EV_INTR);
   assign wr_fault = mem_wr_ack && (mem_wr_acv || mem_wr_tnv);
   assign sp_dec   = sp_q - eis_pkg::LW_BYTES;

   // Trace pending value to save, from the raw event inputs
   always_comb begin
      tp_save = 1'b0;
      unique case (ev_cause)
         eis_pkg::EV_ABORT, eis_pkg::EV_CHM, eis_pkg::EV_TRAP:
            tp_save = cur_psl[eis_pkg::TP_BIT];
         eis_pkg::EV_INTR:
            tp_save = itc_flag ? 1'b0 : cur_psl[eis_pkg::TP_BIT];
         default:
            tp_save = 1'b0;
      endcase
   end

   // PC to save: next instruction for change-mode, trap and trace
   always_comb begin
      unique case (ev_cause)
         eis_pkg::EV_CHM, eis_pkg::EV_TRAP, eis_pkg::EV_TRACE:
            pc_save = next_pc;
         eis_pkg::EV_INTR:
            pc_save = cur_pc;
         default:
            pc_save = cur_pc;
      endcase
   end

   // Stack for the handler: stay on the interrupt stack, else by vector code
   assign stk_new = (cur_psl[eis_pkg::IS_BIT] || ev_vector[1:0] == eis_pkg::VEC_ISTK)
                    ? eis_pkg::SPX_INT : eis_pkg::SPX_KERN;

   // Sequencer side of the stack pointer bank
   always_comb begin
      bank_we    = 1'b0;
      bank_idx   = stk_q;
      bank_wdata = sp_q;
      bank_ridx  = stk_q;
      unique case (state_q)
         eis_pkg::ST_SWITCH: begin
            bank_ridx = stk_q;
            bank_we   = !opsl_q[eis_pkg::IS_BIT];
            bank_idx  = {opsl_q[eis_pkg::IS_BIT], opsl_q[eis_pkg::CUR_LSB +: eis_pkg::MODE_W]};
            bank_wdata = cur_sp;
         end
         eis_pkg::ST_JUMP: begin
            bank_we = 1'b1;
         end
         default: begin
            bank_ridx = eis_pkg::SPX_INT;
         end
      endcase
   end

   eis_sp_bank u_bank (
      .mclk      (mclk),
      .rst       (rst),
      .seq_we    (bank_we),
      .seq_idx   (bank_idx),
      .seq_wdata (bank_wdata),
      .seq_ridx  (bank_ridx),
      .seq_rdata (bank_rdata),
      .prv_we    (prv_we),
      .prv_idx   (prv_idx),
      .prv_wdata (prv_wdata),
      .prv_rdata (prv_rdata)
   );

   // Sequence control
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= eis_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            eis_pkg::ST_IDLE:
               if (ev_start) begin
                  // Codes 2 and 3 are not entry codes; stop rather than guess
                  state_q <= (ev_vector[1] == 1'b1) ? eis_pkg::ST_HALT
                                                    : eis_pkg::ST_SWITCH;
               end
            eis_pkg::ST_SWITCH:
               state_q <= eis_pkg::ST_PUSH_PSL;
            eis_pkg::ST_PUSH_PSL:
               if (wr_fault && stk_q == eis_pkg::SPX_INT) begin
                  state_q <= eis_pkg::ST_HALT;
               end else if (wr_fault) begin
                  state_q <= eis_pkg::ST_PUSH_PSL;
               end else if (mem_wr_ack) begin
                  state_q <= pushpc_q ? eis_pkg::ST_PUSH_PC
                                      : eis_pkg::ST_INIT_PSL;
               end
            eis_pkg::ST_PUSH_PC:
               if (wr_fault && stk_q == eis_pkg::SPX_INT) begin
                  state_q <= eis_pkg::ST_HALT;
               end else if (wr_fault) begin
                  state_q <= eis_pkg::ST_PUSH_PSL;
               end else if (mem_wr_ack) begin
                  state_q <= eis_pkg::ST_INIT_PSL;
               end
            eis_pkg::ST_INIT_PSL:
               state_q <= (pcnt_q != '0 && !ksnv_q) ? eis_pkg::ST_PUSH_PAR
                                                    : eis_pkg::ST_JUMP;
            eis_pkg::ST_PUSH_PAR:
               if (wr_fault && stk_q == eis_pkg::SPX_INT) begin
                  state_q <= eis_pkg::ST_HALT;
               end else if (wr_fault) begin
                  state_q <= eis_pkg::ST_PUSH_PSL;
               end else if (mem_wr_ack && par_q == pcnt_q - 3'h1) begin
                  state_q <= eis_pkg::ST_JUMP;
               end
            eis_pkg::ST_JUMP:
               state_q <= eis_pkg::ST_IDLE;
            eis_pkg::ST_HALT:
               state_q <= eis_pkg::ST_HALT;
         endcase
      end
   end

   // Event capture and stack pointer walk
   always_ff @(posedge mclk) begin
      if (rst) begin
         cause_q  <= eis_pkg::EV_ABORT;
         vec_q    <= 32'h0;
         opsl_q   <= eis_pkg::PSL_RST;
         spsl_q   <= eis_pkg::PSL_RST;
         spc_q    <= 32'h0;
         pushpc_q <= 1'b0;
         pcnt_q   <= 3'h0;
         stk_q    <= eis_pkg::SPX_KERN;
         sp_q     <= 32'h0;
         ksnv_q   <= 1'b0;
         par_q    <= 3'h0;
      end else if (state_q == eis_pkg::ST_IDLE && ev_start) begin
         cause_q  <= eis_cause_cast(ev_cause);
         vec_q    <= ev_vector;
         opsl_q   <= cur_psl;
         spsl_q   <= cur_psl;
         spsl_q[eis_pkg::CC_LSB +: eis_pkg::CC_W] <=
            ev_vector[1] ? cur_psl[eis_pkg::CC_LSB +: eis_pkg::CC_W] : 4'h0;
         spsl_q[eis_pkg::TP_BIT] <= tp_save;
         spc_q    <= pc_save;
         pushpc_q <= !((ev_cause == eis_pkg::EV_INTR && ev_between)
                       || ev_cause == eis_pkg::EV_TRAP);
         pcnt_q   <= par_cnt;
         stk_q    <= stk_new;
         ksnv_q   <= 1'b0;
         par_q    <= 3'h0;
      end else if (state_q == eis_pkg::ST_SWITCH) begin
         sp_q <= (opsl_q[eis_pkg::IS_BIT] || bank_idx == stk_q) ? cur_sp : bank_rdata;
      end else if (wr_fault && stk_q != eis_pkg::SPX_INT) begin
         // Restart the saves on the interrupt stack with the same values
         stk_q    <= eis_pkg::SPX_INT;
         sp_q     <= bank_rdata;
         ksnv_q   <= 1'b1;
         pushpc_q <= 1'b1;
         par_q    <= 3'h0;
      end else if (mem_wr_ack && !wr_fault) begin
         sp_q <= sp_dec;
         if (state_q == eis_pkg::ST_PUSH_PAR) begin
            par_q <= par_q + 3'h1;
         end
      end
   end

   function automatic eis_pkg::eis_cause_t eis_cause_cast(input logic [3:0] c);
      return eis_pkg::eis_cause_t'(c);
   endfunction

   // Memory write port: address is predecremented stack pointer
   always_comb begin
      mem_wr_req  = 1'b0;
      mem_wr_data = spsl_q;
      unique case (state_q)
         eis_pkg::ST_PUSH_PSL: begin
            mem_wr_req  = 1'b1;
            mem_wr_data = spsl_q;
         end
         eis_pkg::ST_PUSH_PC: begin
            mem_wr_req  = 1'b1;
            mem_wr_data = spc_q;
         end
         eis_pkg::ST_PUSH_PAR: begin
            mem_wr_req  = 1'b1;
            mem_wr_data = par_data;
         end
         default: begin
            mem_wr_req  = 1'b0;
         end
      endcase
   end
   assign mem_wr_addr = sp_dec;
   assign par_idx     = par_q;

   // New status longword and handler PC
   always_ff @(posedge mclk) begin
      if (rst) begin
         npsl_q <= eis_pkg::PSL_RST;
         npc_q  <= 32'h0;
      end else if (state_q == eis_pkg::ST_INIT_PSL) begin
         npsl_q <= eis_pkg::PSL_RST;
         npsl_q[eis_pkg::IS_BIT] <= (stk_q == eis_pkg::SPX_INT);
         npsl_q[eis_pkg::IPL_LSB +: eis_pkg::IPL_W] <=
            ksnv_q ? eis_pkg::IPL_KSNV
                   : (intr ? ev_ipl : opsl_q[eis_pkg::IPL_LSB +: eis_pkg::IPL_W]);
      end else if (state_q == eis_pkg::ST_JUMP) begin
         npsl_q[eis_pkg::PREV_LSB +: eis_pkg::MODE_W] <=
            (intr && !ksnv_q) ? eis_pkg::MODE_KERN
                              : opsl_q[eis_pkg::CUR_LSB +: eis_pkg::MODE_W];
         npc_q <= ksnv_q ? {ksnv_vector[31:2], 2'b00} : {vec_q[31:2], 2'b00};
      end else if (state_q == eis_pkg::ST_HALT && !halt_q) begin
         npsl_q <= spsl_q;
         npc_q  <= spc_q;
      end
   end

   // Status pulses and halt level
   always_ff @(posedge mclk) begin
      if (rst) begin
         done_q   <= 1'b0;
         ksnv_p_q <= 1'b0;
         halt_q   <= 1'b0;
      end else begin
         done_q   <= (state_q == eis_pkg::ST_JUMP);
         ksnv_p_q <= wr_fault && stk_q != eis_pkg::SPX_INT && state_q != eis_pkg::ST_HALT;
         halt_q   <= (state_q == eis_pkg::ST_HALT);
      end
   end

   assign int_disable = (state_q != eis_pkg::ST_IDLE) || done_q;
   assign busy        = (state_q != eis_pkg::ST_IDLE);
   assign done        = done_q;
   assign ksnv_abort  = ksnv_p_q;
   assign halted      = halt_q;
   assign new_psl     = npsl_q;
   assign new_pc      = npc_q;
   assign new_sp      = sp_q;

   property p_intdis;
      @(posedge mclk) disable iff (rst)
      (ev_start || state_q != eis_pkg::ST_IDLE) |=> int_disable;
   endproperty
   a_intdis: assert property (p_intdis) else $error("interrupts enabled during entry");

   property p_cc;
      @(posedge mclk) disable iff (rst)
      (state_q == eis_pkg::ST_PUSH_PSL && !vec_q[1]) |-> mem_wr_data[3:0] == 4'h0;
   endproperty
   a_cc: assert property (p_cc) else $error("condition codes not cleared");

   property p_order;
      @(posedge mclk) disable iff (rst)
      (state_q == eis_pkg::ST_PUSH_PC) |->
         $past(state_q) inside {eis_pkg::ST_PUSH_PSL, eis_pkg::ST_PUSH_PC};
   endproperty
   a_order: assert property (p_order) else $error("PC pushed before status");

   property p_predec;
      @(posedge mclk) disable iff (rst)
      (mem_wr_req && mem_wr_ack && !wr_fault) |=> sp_q == $past(mem_wr_addr)
         && $past(mem_wr_addr) == $past(sp_q) - 32'h4;
   endproperty
   a_predec: assert property (p_predec) else $error("stack not predecremented by four");

   property p_jump;
      @(posedge mclk) disable iff (rst)
      (state_q == eis_pkg::ST_JUMP && !ksnv_q) |=>
         new_pc == {$past(vec_q[31:2]), 2'b00} ##1 done_q == 1'b0;
   endproperty
   a_jump: assert property (p_jump) else $error("handler PC not from vector");

   property p_ksnv;
      @(posedge mclk) disable iff (rst)
      (state_q == eis_pkg::ST_JUMP && ksnv_q) |=>
         new_psl[eis_pkg::IPL_LSB +: eis_pkg::IPL_W] == 5'h1f && new_psl[eis_pkg::IS_BIT];
   endproperty
   a_ksnv: assert property (p_ksnv) else $error("kernel stack abort level wrong");

   property p_ipl;
      @(posedge mclk) disable iff (rst)
      (state_q == eis_pkg::ST_JUMP && !intr && !ksnv_q) |=>
         new_psl[eis_pkg::IPL_LSB +: eis_pkg::IPL_W] == $past(opsl_q[20:16]);
   endproperty
   a_ipl: assert property (p_ipl) else $error("priority changed for exception");

   property p_mode;
      @(posedge mclk) disable iff (rst)
      done_q |-> new_psl[eis_pkg::CUR_LSB +: eis_pkg::MODE_W] == 2'h0;
   endproperty
   a_mode: assert property (p_mode) else $error("current mode not cleared");

   property p_halt;
      @(posedge mclk) disable iff (rst)
      halt_q |=> halt_q && $stable(new_pc) && $stable(new_psl) && !mem_wr_req;
   endproperty
   a_halt: assert property (p_halt) else $error("halt state not held");
endmodule // eis_entry_seq
`default_nettype wire

/* tb/eis_mem_model.sv */
// Stack memory partner: acks writes after a set delay, faults inside an address window, logs writes
`timescale 1ns/1ps
`default_nettype none
module eis_mem_model (
   input  wire logic        mclk, // Clock
   input  wire logic        rst,  // Sync reset
   input  wire logic        req,  // Write request
   input  wire logic [31:0] addr, // Write address
   input  wire logic [31:0] data, // Write data
   input  wire logic [1:0]  dly,  // Ack delay in cycles
   input  wire logic [31:0] flo,  // Fault window low
   input  wire logic [31:0] fhi,  // Fault window high
   input  wire logic        ftnv, // Fault as translation not valid
   input  wire logic        clr,  // Clear the write log
   output logic             ack,  // Write done
   output logic             acv,  // Access violation
   output logic             tnv   // Translation not valid
);
   logic [1:0]  cnt_q;
   logic        flt;
   logic [31:0] wa [16];
   logic [31:0] wd [16];
   int          n_wr;
   assign flt = (addr >= flo) && (addr <= fhi);
   always_ff @(posedge mclk) begin
      if (rst || ack) begin
         ack   <= 1'b0;
         cnt_q <= 2'h0;
      end else if (req && cnt_q == dly) begin
         ack <= 1'b1;
      end else if (req) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
   // Fault flags mean nothing without ack, so they wander then
   always_ff @(posedge mclk) begin
      if (rst) begin
         acv <= 1'b0;
         tnv <= 1'b0;
      end else if (req && !ack && cnt_q == dly) begin
         acv <= flt && !ftnv;
         tnv <= flt && ftnv;
      end else begin
         acv <= ~acv;
         tnv <= ~tnv;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst || clr) begin
         n_wr <= 0;
      end else if (req && ack && !acv && !tnv) begin
         wa[n_wr[3:0]] <= addr;
         wd[n_wr[3:0]] <= data;
         n_wr          <= n_wr + 1;
      end
   end
endmodule // eis_mem_model
`default_nettype wire

/* tb/eis_entry_seq_tb_top.sv */
// Self-checking bench for the event entry sequencer
`timescale 1ns/1ps
`default_nettype none
module eis_entry_seq_tb_top;
   localparam logic [31:0] PSL0 = 32'h4303_000f;
   localparam logic [31:0] CPC = 32'h0000_8000;
   localparam logic [31:0] NPC = 32'h0000_8004;
   logic mclk, rst, ev_start, ev_between, itc_flag, prv_we, ftnv, clr, tp, saw_ksnv;
   logic mem_wr_req, mem_wr_ack, mem_wr_acv, mem_wr_tnv, int_disable, busy, done, ksnv_abort, halted;
   logic [1:0]  dly;
   logic [2:0]  par_cnt, par_idx, prv_idx;
   logic [3:0]  ev_cause;
   logic [4:0]  ev_ipl;
   logic [31:0] ev_vector, ksnv_vector, cur_psl, cur_sp, par_data, mem_wr_addr, mem_wr_data;
   logic [31:0] prv_wdata, prv_rdata, new_psl, new_pc, new_sp, flo, fhi, interrupt_stack_pointer;
   int          n_mismatch, num_checks, cyc;
   assign par_data = 32'hca00_0000 | {29'h0, par_idx};
   eis_entry_seq u_eis_entry_seq (.mclk(mclk), .rst(rst), .ev_start(ev_start),
      .ev_cause(ev_cause), .ev_between(ev_between), .itc_flag(itc_flag), .ev_ipl(ev_ipl),
      .ev_vector(ev_vector), .ksnv_vector(ksnv_vector), .cur_psl(cur_psl), .cur_pc(CPC),
      .next_pc(NPC), .cur_sp(cur_sp), .par_cnt(par_cnt), .par_data(par_data),
      .par_idx(par_idx), .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack), .mem_wr_acv(mem_wr_acv),
      .mem_wr_tnv(mem_wr_tnv), .prv_we(prv_we), .prv_idx(prv_idx), .prv_wdata(prv_wdata),
      .prv_rdata(prv_rdata), .int_disable(int_disable), .busy(busy), .done(done),
      .ksnv_abort(ksnv_abort), .halted(halted), .new_psl(new_psl), .new_pc(new_pc),
      .new_sp(new_sp));
   eis_mem_model u_eis_mem_model (.mclk(mclk), .rst(rst), .req(mem_wr_req),
      .addr(mem_wr_addr), .data(mem_wr_data), .dly(dly), .flo(flo), .fhi(fhi), .ftnv(ftnv),
      .clr(clr), .ack(mem_wr_ack), .acv(mem_wr_acv), .tnv(mem_wr_tnv));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkw(input int i, input logic [31:0] a, input logic [31:0] d);
      chk("wr_addr", a, u_eis_mem_model.wa[i]);
      chk("wr_data", d, u_eis_mem_model.wd[i]);
   endtask
   task automatic rd(input logic [2:0] i, input logic [31:0] e);
      @(posedge mclk);
      prv_idx <= i;
      @(negedge mclk);
      chk("prv_rdata", e, prv_rdata);
   endtask
   task automatic prv_wr(input logic [2:0] i, input logic [31:0] d);
      @(posedge mclk);
      prv_we    <= 1'b1;
      prv_idx   <= i;
      prv_wdata <= d;
      @(posedge mclk);
      prv_we <= 1'b0;
   endtask
   // One entry: start pulse, then wait for done or halt while watching the abort pulse
   task automatic run(input logic [3:0] c, input logic [31:0] v, input logic [2:0] np,
                      input logic btw, input logic itc);
      @(posedge mclk);
      ev_start   <= 1'b1;
      ev_cause   <= c;
      ev_vector  <= v;
      par_cnt    <= np;
      ev_between <= btw;
      itc_flag   <= itc;
      clr        <= 1'b1;
      saw_ksnv   = 1'b0;
      @(posedge mclk);
      ev_start <= 1'b0;
      clr      <= 1'b0;
      for (int k = 0; k < 300; k++) begin
         @(negedge mclk);
         if (k == 0 && !halted) chk("int_disable", 32'h1, {31'h0, int_disable});
         if (ksnv_abort === 1'b1) saw_ksnv = 1'b1;
         if (done === 1'b1 || halted === 1'b1) break;
      end
      if (!halted) chk("int_dis_done", 32'h1, {31'h0, int_disable});
   endtask
   initial begin
      {rst, ev_start, ev_between, itc_flag, prv_we, ftnv, clr} = 7'h40;
      {dly, par_cnt, prv_idx, ev_cause} = 12'h800;
      ev_ipl = 5'h14;
      ev_vector = 32'h0;
      ksnv_vector = 32'h0000_7001;
      cur_psl = PSL0;
      cur_sp = 32'h0000_3000;
      prv_wdata = 32'h0;
      flo = 32'h1;
      fhi = 32'h0;
      interrupt_stack_pointer = 32'h0000_2000;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(3'h1, 32'h0);
      @(posedge mclk);
      cur_psl <= 32'h4003_000f;
      run(4'h1, 32'h0000_5000, 3'h0, 1'b0, 1'b0);
      chkw(0, 32'h0000_2ffc, 32'h0003_0000);
      chk("new_sp", 32'h0000_2ff8, new_sp);
      @(posedge mclk);
      cur_psl <= PSL0;
      prv_wr(3'h0, 32'h0000_1000);
      prv_wr(3'h4, interrupt_stack_pointer);
      rd(3'h5, 32'h0);
      run(4'h3, 32'h0000_5000, 3'h2, 1'b0, 1'b0);
      chk("n_wr", 32'h4, u_eis_mem_model.n_wr);
      chkw(0, 32'h0000_0ffc, 32'h0303_0000);
      chkw(1, 32'h0000_0ff8, CPC);
      chkw(3, 32'h0000_0ff0, 32'hca00_0001);
      chk("new_pc", 32'h0000_5000, new_pc);
      chk("new_psl", 32'h00c3_0000, new_psl);
      chk("new_sp", 32'h0000_0ff0, new_sp);
      rd(3'h3, 32'h0000_3000);
      rd(3'h0, 32'h0000_0ff0);
      @(posedge mclk);
      dly <= 2'h0;
      for (int c = 0; c < 9; c++) begin
         tp = (c == 0 || c == 2 || c == 4 || c == 6);
         run(c[3:0], 32'h0000_6001, 3'h0, 1'b0, 1'b0);
         chkw(0, interrupt_stack_pointer - 32'h4, tp ? 32'h4303_0000 : 32'h0303_0000);
         if (c != 6) chkw(1, interrupt_stack_pointer - 32'h8, (c == 2 || c == 5) ? NPC : CPC);
         interrupt_stack_pointer = interrupt_stack_pointer - ((c == 6) ? 32'h4 : 32'h8);
         chk("n_wr", (c == 6) ? 32'h1 : 32'h2, u_eis_mem_model.n_wr);
         chk("new_sp", interrupt_stack_pointer, new_sp);
         chk("new_psl", {5'h0, 1'b1, 2'h0, (c == 4) ? 2'h0 : 2'h3, 1'b0,
             (c == 4) ? 5'h14 : 5'h03, 16'h0}, new_psl);
      end
      run(4'h4, 32'h0000_6001, 3'h0, 1'b1, 1'b1);
      chk("n_wr", 32'h1, u_eis_mem_model.n_wr);
      chkw(0, interrupt_stack_pointer - 32'h4, 32'h0303_0000);
      interrupt_stack_pointer = interrupt_stack_pointer - 32'h4;
      @(posedge mclk);
      flo <= 32'h0;
      fhi <= 32'h0000_0fff;
      run(4'h3, 32'h0000_5000, 3'h2, 1'b0, 1'b0);
      chk("ksnv_abort", 32'h1, {31'h0, saw_ksnv});
      chk("n_wr", 32'h2, u_eis_mem_model.n_wr);
      chkw(0, interrupt_stack_pointer - 32'h4, 32'h0303_0000);
      chkw(1, interrupt_stack_pointer - 32'h8, CPC);
      chk("new_pc", 32'h0000_7000, new_pc);
      chk("new_ipl_is", 32'h0000_003f, {26'h0, new_psl[26], new_psl[20:16]});
      interrupt_stack_pointer = interrupt_stack_pointer - 32'h8;
      @(posedge mclk);
      fhi <= 32'h0000_ffff;
      ftnv <= 1'b1;
      run(4'h3, 32'h0000_5001, 3'h1, 1'b0, 1'b0);
      chk("halted", 32'h1, {31'h0, halted});
      chk("halt_psl", 32'h0303_0000, new_psl);
      chk("halt_pc", CPC, new_pc);
      chk("halt_sp", interrupt_stack_pointer, new_sp);
      run(4'h1, 32'h0000_5001, 3'h0, 1'b0, 1'b0);
      chk("halt_busy", 32'h1, {31'h0, busy});
      chk("halt_pc_kept", CPC, new_pc);
      chk("n_wr", 32'h0, u_eis_mem_model.n_wr);
      final_report();
   end
endmodule // eis_entry_seq_tb_top
`default_nettype wire
